// ==== rtl/eeprom_pkg.sv ====
package eeprom_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and write cycle timing
    localparam int unsigned SYS_CLK_HZ   = 40000000;
    localparam int unsigned MS_PER_S     = 1000;
    localparam int unsigned WR_CYCLE_MS  = 5;
    // longest time, so rounded down to whole cycles
    localparam int unsigned WR_CYCLE_CYC = SYS_CLK_HZ / MS_PER_S * WR_CYCLE_MS;

    ////////////////////////////////////////////////////////////////////////
    // array geometry and word layout
    localparam int ADDR_W    = 14;
    localparam int PAGE_W    = 6;
    localparam int DATA_W    = 8;
    localparam int HI_W      = ADDR_W - DATA_W;
    localparam int SEL_W     = 3;
    localparam int MEM_DEPTH = 16384;

    localparam logic [3:0]        DEV_TYPE   = 4'ha;
    localparam logic [3:0]        BIT_ZERO   = 4'h0;
    localparam logic [3:0]        BIT_STEP   = 4'h1;
    localparam logic [3:0]        LAST_BIT   = 4'h7;
    localparam logic [3:0]        ACK_BIT    = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0000;
    localparam logic [ADDR_W-1:0] ADDR_STEP  = 14'h0001;
    localparam logic [PAGE_W-1:0] PAGE_STEP  = 6'h01;

    ////////////////////////////////////////////////////////////////////////
    // events sent from the serial clock side to the system side
    typedef enum logic [1:0] {
        EV_SET_ADDR,
        EV_WRITE,
        EV_NEXT,
        EV_IDLE
    } ev_kind_e;

    typedef struct packed {
        ev_kind_e          kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } link_ev_s;

    // only the in-page bits advance; the page row stays put
    function automatic logic [ADDR_W-1:0] page_inc(
        input logic [ADDR_W-1:0] a
    );
        return {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + PAGE_STEP};
    endfunction

    function automatic link_ev_s mk_ev(
        input ev_kind_e          kind,
        input logic [ADDR_W-1:0] addr,
        input logic [DATA_W-1:0] data
    );
        link_ev_s e;
        e.kind = kind;
        e.addr = addr;
        e.data = data;
        return e;
    endfunction

endpackage

// ==== rtl/eeprom_cell_array.sv ====
`timescale 1ns/1ps
`default_nettype none

// byte array with one write port and a registered read port
module eeprom_cell_array (
    input  wire logic                          clk,
    input  wire logic                          we,
    input  wire logic [eeprom_pkg::ADDR_W-1:0] waddr,
    input  wire logic [eeprom_pkg::DATA_W-1:0] wdata,
    input  wire logic [eeprom_pkg::ADDR_W-1:0] raddr,
    output logic      [eeprom_pkg::DATA_W-1:0] rdata
);

    logic [eeprom_pkg::DATA_W-1:0] cells [eeprom_pkg::MEM_DEPTH];

    // cell contents carry no reset, as a real array would not
    always_ff @(posedge clk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
    end

    // read data always comes from a flop
    always_ff @(posedge clk) begin
        rdata <= cells[raddr];
    end

endmodule

`default_nettype wire

// ==== rtl/two_wire_serial_eeprom_slave.sv ====
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - sda moves only while scl is low
// - sda falling with scl high is start
// - sda rising with scl high is stop
// - eight-bit words, device acks in ninth clock
// - standby at reset and after stop, when idle
// - 256 pages of 64 bytes, 14-bit address
// - device word must open with one-zero-one-zero
// - three select bits compared with strapped inputs
// - floating select input reads as low
// - last device word bit: one read, zero write
// - match acks; mismatch goes idle until start
// - write protect high blocks all array writes
// - byte write: address bytes, data, each acked
// - stop after write runs timed busy cycle
// - page write takes up to 63 more bytes
// - write address wraps inside the page
// - no ack while busy; ack once done
// - sample on scl rise, drive after fall
// - counter holds last address plus one
// - acked reads advance, wrapping at array end
// - read ends on nack then stop
module two_wire_serial_eeprom_slave #(
    parameter int unsigned WR_CYCLES = eeprom_pkg::WR_CYCLE_CYC
) (
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe,
    input  wire logic [eeprom_pkg::SEL_W-1:0] chip_select_straps,
    input  wire logic                         write_protect,
    output logic                              standby
);

    localparam int TMR_W = $clog2(WR_CYCLES + 1);
    localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(WR_CYCLES);
    localparam logic [TMR_W-1:0] TMR_ONE  = TMR_W'(1);
    localparam logic [TMR_W-1:0] TMR_ZERO = TMR_W'(0);
    localparam int BYTE_TOP = eeprom_pkg::DATA_W - 2;

    typedef enum logic [2:0] {
        S_IDLE,
        S_DEV,
        S_AHI,
        S_ALO,
        S_WDAT,
        S_RDAT
    } link_state_e;

    ////////////////////////////////////////////////////////////////////////
    // link side: start and stop seen on the data line's own edges

    logic start_tog_r;
    logic stop_tog_r;

    // start toggles on a falling data line while scl is high
    always_ff @(negedge sda_in or posedge reset) begin
        if (reset) begin
            start_tog_r <= 1'b0;
        end else if (scl_in) begin
            start_tog_r <= ~start_tog_r;
        end
    end

    // stop toggles on a rising data line while scl is high
    always_ff @(posedge sda_in or posedge reset) begin
        if (reset) begin
            stop_tog_r <= 1'b0;
        end else if (scl_in) begin
            stop_tog_r <= ~stop_tog_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link side: bit counter and data line drive on falling scl

    link_state_e                      state_r;
    logic                             start_seen_r;
    logic                             new_frame_r;
    logic [3:0]                       bit_cnt_r;
    logic [3:0]                       bit_nxt;
    logic                             drive_r;
    logic                             ack_r;
    logic [eeprom_pkg::DATA_W-1:0]    tx_r;
    logic                             start_pend;

    assign start_pend = (start_tog_r != start_seen_r);

    // nine clocks per word: eight bits and the acknowledge slot
    always_comb begin
        if (bit_cnt_r == eeprom_pkg::ACK_BIT) begin
            bit_nxt = eeprom_pkg::BIT_ZERO;
        end else begin
            bit_nxt = bit_cnt_r + eeprom_pkg::BIT_STEP;
        end
    end

    // a start restarts the word count at the next falling scl
    always_ff @(negedge scl_in or posedge reset) begin
        if (reset) begin
            start_seen_r <= 1'b0;
            new_frame_r  <= 1'b0;
            bit_cnt_r    <= eeprom_pkg::BIT_ZERO;
        end else if (start_pend) begin
            start_seen_r <= start_tog_r;
            new_frame_r  <= 1'b1;
            bit_cnt_r    <= eeprom_pkg::BIT_ZERO;
        end else begin
            new_frame_r  <= 1'b0;
            bit_cnt_r    <= bit_nxt;
        end
    end

    // drive changes only after falling scl, so sda never moves mid-high
    always_ff @(negedge scl_in or posedge reset) begin
        if (reset) begin
            drive_r <= 1'b0;
        end else if (start_pend) begin
            drive_r <= 1'b0;
        end else if (bit_nxt == eeprom_pkg::ACK_BIT) begin
            drive_r <= ack_r;
        end else if (state_r == S_RDAT) begin
            drive_r <= ~tx_r[~bit_nxt[2:0]]; // msb first
        end else begin
            drive_r <= 1'b0;
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = drive_r;

    ////////////////////////////////////////////////////////////////////////
    // link side: level inputs brought onto rising scl

    logic [eeprom_pkg::SEL_W-1:0] sel_s1_r;
    logic [eeprom_pkg::SEL_W-1:0] sel_s2_r;
    logic [1:0]                   busy_sync_r;
    logic                         busy_r;

    // floating straps are pulled low by the pad bias before this point
    always_ff @(posedge scl_in or posedge reset) begin
        if (reset) begin
            sel_s1_r    <= '0;
            sel_s2_r    <= '0;
            busy_sync_r <= 2'h0;
        end else begin
            sel_s1_r    <= chip_select_straps;
            sel_s2_r    <= sel_s1_r;
            busy_sync_r <= {busy_sync_r[0], busy_r};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link side: word decode on rising scl

    logic [eeprom_pkg::DATA_W-1:0] shift_r;
    logic [eeprom_pkg::DATA_W-1:0] in_byte;
    logic [eeprom_pkg::HI_W-1:0]   addr_hi_r;
    logic                          rd_dir_r;
    logic                          dev_match;
    eeprom_pkg::link_ev_s          ev_r;
    logic                          ev_tog_r;
    logic [eeprom_pkg::DATA_W-1:0] rd_data_q;

    assign in_byte = {shift_r[BYTE_TOP:0], sda_in};
    // type nibble, then straps; direction bit is not part of the match
    assign dev_match = (in_byte[7:4] == eeprom_pkg::DEV_TYPE)
                    && (in_byte[3:1] == sel_s2_r);

    // sample sda on rising scl; decide ack after the eighth bit
    always_ff @(posedge scl_in or posedge reset) begin
        if (reset) begin
            state_r   <= S_IDLE;
            shift_r   <= '0;
            ack_r     <= 1'b0;
            rd_dir_r  <= 1'b0;
            addr_hi_r <= '0;
            tx_r      <= '0;
            ev_r      <= '0;
            ev_tog_r  <= 1'b0;
        end else begin
            if (bit_cnt_r != eeprom_pkg::ACK_BIT) begin
                shift_r <= in_byte;
            end
            if (new_frame_r) begin
                state_r <= S_DEV;
                ack_r   <= 1'b0;
            end else if (bit_cnt_r == eeprom_pkg::LAST_BIT) begin
                ack_r <= 1'b0;
                case (state_r)
                    S_DEV: begin
                        rd_dir_r <= sda_in;
                        if (dev_match && !busy_sync_r[1]) begin
                            ack_r <= 1'b1;
                        end else begin
                            state_r  <= S_IDLE;
                            ev_r     <= eeprom_pkg::mk_ev(
                                eeprom_pkg::EV_IDLE, '0, '0);
                            ev_tog_r <= ~ev_tog_r;
                        end
                    end
                    S_AHI: begin
                        ack_r     <= 1'b1;
                        addr_hi_r <= in_byte[eeprom_pkg::HI_W-1:0];
                    end
                    S_ALO: begin
                        ack_r    <= 1'b1;
                        ev_r     <= eeprom_pkg::mk_ev(eeprom_pkg::EV_SET_ADDR,
                            {addr_hi_r, in_byte}, '0);
                        ev_tog_r <= ~ev_tog_r;
                    end
                    S_WDAT: begin
                        // acked even when protected; the array decides
                        ack_r    <= 1'b1;
                        ev_r     <= eeprom_pkg::mk_ev(eeprom_pkg::EV_WRITE,
                            '0, in_byte);
                        ev_tog_r <= ~ev_tog_r;
                    end
                    default: begin
                        ack_r <= 1'b0;
                    end
                endcase
            end else if (bit_cnt_r == eeprom_pkg::ACK_BIT) begin
                case (state_r)
                    S_DEV: begin
                        if (rd_dir_r) begin
                            state_r  <= S_RDAT; // current address
                            tx_r     <= rd_data_q;
                            ev_r     <= eeprom_pkg::mk_ev(
                                eeprom_pkg::EV_NEXT, '0, '0);
                            ev_tog_r <= ~ev_tog_r;
                        end else begin
                            state_r <= S_AHI;
                        end
                    end
                    S_AHI: begin
                        state_r <= S_ALO;
                    end
                    S_ALO: begin
                        state_r <= S_WDAT;
                    end
                    S_RDAT: begin
                        if (!sda_in) begin
                            tx_r     <= rd_data_q;
                            ev_r     <= eeprom_pkg::mk_ev(
                                eeprom_pkg::EV_NEXT, '0, '0);
                            ev_tog_r <= ~ev_tog_r;
                        end else begin
                            state_r  <= S_IDLE; // line released
                            ev_r     <= eeprom_pkg::mk_ev(
                                eeprom_pkg::EV_IDLE, '0, '0);
                            ev_tog_r <= ~ev_tog_r;
                        end
                    end
                    default: begin
                        state_r <= state_r;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system side: crossings into sys_clk

    logic [2:0] ev_sync_r;
    logic [2:0] start_sync_r;
    logic [2:0] stop_sync_r;
    logic [1:0] wp_sync_r;
    logic       ev_p;
    logic       start_p;
    logic       stop_p;

    // toggles pass two flops, then the edge is taken between the later two
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ev_sync_r    <= 3'h0;
            start_sync_r <= 3'h0;
            stop_sync_r  <= 3'h0;
            wp_sync_r    <= 2'h0;
        end else begin
            ev_sync_r    <= {ev_sync_r[1:0], ev_tog_r};
            start_sync_r <= {start_sync_r[1:0], start_tog_r};
            stop_sync_r  <= {stop_sync_r[1:0], stop_tog_r};
            wp_sync_r    <= {wp_sync_r[0], write_protect};
        end
    end

    assign ev_p    = ev_sync_r[2] ^ ev_sync_r[1];
    assign start_p = start_sync_r[2] ^ start_sync_r[1];
    assign stop_p  = stop_sync_r[2] ^ stop_sync_r[1];

    ////////////////////////////////////////////////////////////////////////
    // system side: address counter and array

    logic [eeprom_pkg::ADDR_W-1:0] addr_ctr_r;
    logic                          mem_we;

    // payload in ev_r is stable: it changed at least two syncs earlier
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            addr_ctr_r <= eeprom_pkg::ADDR_RESET;
        end else if (ev_p) begin
            case (ev_r.kind)
                eeprom_pkg::EV_SET_ADDR: begin
                    addr_ctr_r <= ev_r.addr;
                end
                eeprom_pkg::EV_WRITE: begin
                    addr_ctr_r <= eeprom_pkg::page_inc(addr_ctr_r);
                end
                eeprom_pkg::EV_NEXT: begin
                    // full width wrap, last byte back to the first
                    addr_ctr_r <= addr_ctr_r + eeprom_pkg::ADDR_STEP;
                end
                default: begin
                    addr_ctr_r <= addr_ctr_r;
                end
            endcase
        end
    end

    // bytes land as they arrive; protection simply drops them
    assign mem_we = ev_p && (ev_r.kind == eeprom_pkg::EV_WRITE)
                 && !wp_sync_r[1];

    eeprom_cell_array eeprom_cell_array_inst (
        .clk   (sys_clk),
        .we    (mem_we),
        .waddr (addr_ctr_r),
        .wdata (ev_r.data),
        .raddr (addr_ctr_r),
        .rdata (rd_data_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // system side: timed write cycle and standby

    logic             pend_wr_r;
    logic [TMR_W-1:0] wr_cnt_r;
    logic             in_frame_r;
    logic             standby_nxt;
    logic             standby_r;

    // set wins over clear when both land together
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pend_wr_r <= 1'b0;
        end else if (mem_we) begin
            pend_wr_r <= 1'b1;
        end else if (stop_p) begin
            pend_wr_r <= 1'b0;
        end
    end

    // only a stop after committed bytes starts the busy time
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_cnt_r <= TMR_ZERO;
            busy_r   <= 1'b0;
        end else if (stop_p && pend_wr_r) begin
            wr_cnt_r <= TMR_LOAD;
            busy_r   <= 1'b1;
        end else if (wr_cnt_r != TMR_ZERO) begin
            wr_cnt_r <= wr_cnt_r - TMR_ONE;
            busy_r   <= (wr_cnt_r != TMR_ONE);
        end
    end

    // frame opens on start, closes on stop or when the device drops out
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            in_frame_r <= 1'b0;
        end else if (start_p) begin
            in_frame_r <= 1'b1;
        end else if (stop_p) begin
            in_frame_r <= 1'b0;
        end else if (ev_p && (ev_r.kind == eeprom_pkg::EV_IDLE)) begin
            in_frame_r <= 1'b0;
        end
    end

    assign standby_nxt = !in_frame_r && !busy_r && !pend_wr_r;

    // low power once no frame and no internal work remain
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            standby_r <= 1'b1;
        end else begin
            standby_r <= standby_nxt;
        end
    end

    assign standby = standby_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence wr_ev_s;
        ev_p && (ev_r.kind == eeprom_pkg::EV_WRITE);
    endsequence

    sequence next_ev_s;
        ev_p && (ev_r.kind == eeprom_pkg::EV_NEXT);
    endsequence

    sequence stop_idle_s;
        stop_p && !pend_wr_r && !busy_r && !start_p;
    endsequence

    busy_start_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        stop_p && pend_wr_r |=> busy_r && (wr_cnt_r == TMR_LOAD))
        else $error("write cycle did not start after stop");

    busy_hold_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        $rose(busy_r) |-> busy_r [*8])
        else $error("write cycle ended too early");

    wp_guard_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        mem_we |-> !wp_sync_r[1])
        else $error("array written while protected");

    wp_noburn_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        wr_ev_s ##0 wp_sync_r[1] |=> !pend_wr_r || $past(pend_wr_r))
        else $error("protected byte armed a write cycle");

    page_wrap_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        wr_ev_s |=> (addr_ctr_r[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W]
            == $past(addr_ctr_r[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W]))
            && (addr_ctr_r[eeprom_pkg::PAGE_W-1:0]
            == $past(addr_ctr_r[eeprom_pkg::PAGE_W-1:0])
            + eeprom_pkg::PAGE_STEP))
        else $error("write address left its page");

    read_next_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        next_ev_s |=> addr_ctr_r == $past(addr_ctr_r) + eeprom_pkg::ADDR_STEP)
        else $error("read address did not advance by one");

    standby_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        stop_idle_s |=> ##1 standby)
        else $error("no standby after idle stop");

    busy_quiet_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        busy_r |=> !standby)
        else $error("standby during write cycle");

    dev_nack_a: assert property (
        @(posedge scl_in) disable iff (reset)
        (state_r == S_DEV) && (bit_cnt_r == eeprom_pkg::LAST_BIT)
        && busy_sync_r[1] && !new_frame_r |=> !ack_r && (state_r == S_IDLE))
        else $error("device acked while busy");

    bit_range_a: assert property (
        @(negedge scl_in) disable iff (reset)
        bit_cnt_r <= eeprom_pkg::ACK_BIT)
        else $error("bit count out of range");

    ack_drive_a: assert property (
        @(negedge scl_in) disable iff (reset)
        !start_pend && (bit_nxt == eeprom_pkg::ACK_BIT) && ack_r
        |=> sda_oe && (bit_cnt_r == eeprom_pkg::ACK_BIT))
        else $error("ack not driven in ninth clock");

endmodule

`default_nettype wire

// ==== test/bus_controller.sv ====
`timescale 1ns/1ps
`default_nettype none

// behavioural controller; scl stands high between frames
module bus_controller (
    output var logic scl,
    output var logic sda_pull,
    input  wire logic sda
);
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one 30 ns bit; sda moves only while scl is low
    task automatic bit_x(input logic b, output logic r);
        sda_pull = ~b;
        #8 scl = 1'b1;
        #7 r = sda;
        #8 scl = 1'b0;
        #7;
    endtask

    // works from idle and as a repeated start
    task automatic start_c();
        sda_pull = 1'b0;
        #8 scl = 1'b1;
        #8 sda_pull = 1'b1;
        #8 scl = 1'b0;
        #7;
    endtask

    task automatic stop_c();
        sda_pull = 1'b1;
        #8 scl = 1'b1;
        #8 sda_pull = 1'b0;
        #15;
    endtask

    // after a broken transfer: clock until sda reads high, then start
    task automatic recover();
        logic r;
        r = 1'b0;
        for (int i = 0; i < 9 && !r; i++) bit_x(1'b1, r);
        start_c();
    endtask

    // msb first, ninth bit released to read the ack
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask

    // more low leaves the ack high to end a read
    task automatic recv(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            b[i] = r;
        end
        bit_x(~more, r);
    endtask
endmodule

`default_nettype wire

// ==== test/two_wire_serial_eeprom_slave_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module two_wire_serial_eeprom_slave_tb;
    localparam int unsigned WR_N = 40;
    logic       sys_clk, reset, scl, sda_pull, sda_out, sda_oe, wp, standby;
    logic [2:0] straps;
    logic [7:0] rd [3];
    logic       ack;
    int         bad_count, n_compared, cyc;
    wire logic  sda;

    // open drain wire with pull-up
    assign sda = ~(sda_pull | (sda_oe & ~sda_out));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    bus_controller bus_controller_inst (.scl(scl), .sda_pull(sda_pull),
        .sda(sda));
    two_wire_serial_eeprom_slave #(.WR_CYCLES(WR_N))
        two_wire_serial_eeprom_slave_inst (.sys_clk(sys_clk),
        .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .chip_select_straps(straps),
        .write_protect(wp), .standby(standby));

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string w, input logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic dev(input logic [2:0] sel, input logic rw, input logic e);
        bus_controller_inst.start_c();
        bus_controller_inst.send({4'ha, sel, rw}, ack);
        chk("dev ack", {7'h0, e}, {7'h0, ack});
    endtask

    task automatic send_b(input logic [7:0] b);
        bus_controller_inst.send(b, ack);
        chk("byte ack", 8'h01, {7'h0, ack});
    endtask

    // word address then data; device word already sent
    task automatic wr(input logic [7:0] hi, lo, input int n,
        input logic [7:0] d [3]);
        send_b(hi);
        send_b(lo);
        for (int i = 0; i < n; i++) send_b(d[i]);
        bus_controller_inst.stop_c();
    endtask

    // random read via dummy write, or current read when rnd is low
    task automatic rd_n(input logic rnd, input logic [7:0] hi, lo, int n);
        if (rnd) begin
            dev(straps, 1'b0, 1'b1);
            send_b(hi);
            send_b(lo);
            #60;
        end
        dev(straps, 1'b1, 1'b1);
        for (int i = 0; i < n; i++) bus_controller_inst.recv(i < n - 1, rd[i]);
        bus_controller_inst.stop_c();
    endtask

    // bounded wait for the busy time to run out
    task automatic wait_ready();
        for (int i = 0; i < 2 * WR_N && standby !== 1'b1; i++)
            @(negedge sys_clk);
        @(negedge sys_clk);
        chk("standby", 8'h01, {7'h0, standby});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two bytes, then polling while busy gets no ack
    task automatic t_write_poll();
        dev(straps, 1'b0, 1'b1);
        wr(8'h00, 8'h00, 2, '{8'h5a, 8'h3c, 8'h00});
        repeat (8) @(negedge sys_clk);
        chk("busy", 8'h00, {7'h0, standby});
        dev(straps, 1'b0, 1'b0);
        bus_controller_inst.stop_c();
        wait_ready();
        $display("write and poll done");
    endtask

    // wrong straps on a free device: no ack, back to standby
    task automatic t_mismatch();
        dev(3'h2, 1'b0, 1'b0);
        bus_controller_inst.stop_c();
        repeat (4) @(negedge sys_clk);
        chk("nack standby", 8'h01, {7'h0, standby});
        $display("mismatch done");
    endtask

    // three bytes from 3ffe; the third wraps to the start of the same page, then wait for ready
    task automatic t_page_wrap();
        dev(straps, 1'b0, 1'b1);
        wr(8'hff, 8'hfe, 3, '{8'ha1, 8'ha2, 8'ha3});
        wait_ready();
        $display("page wrap done");
    endtask

    // random, sequential and current reads; line let go at the end
    task automatic t_reads();
        rd_n(1'b1, 8'h3f, 8'hff, 2);
        chk("rd 3fff", 8'ha2, rd[0]);
        chk("rd 0000", 8'h5a, rd[1]);
        rd_n(1'b0, 8'h00, 8'h00, 1);
        chk("rd cur", 8'h3c, rd[0]);
        rd_n(1'b1, 8'h3f, 8'hc0, 1);
        chk("rd 3fc0", 8'ha3, rd[0]);
        repeat (4) @(negedge sys_clk);
        chk("standby", 8'h01, {7'h0, standby});
        chk("rd oe", 8'h00, {7'h0, sda_oe});
        $display("reads done");
    endtask

    // protected write is acked, starts no busy time, changes nothing
    task automatic t_protect();
        wp = 1'b1;
        repeat (4) @(negedge sys_clk);
        dev(straps, 1'b0, 1'b1);
        wr(8'h00, 8'h00, 1, '{8'h77, 8'h00, 8'h00});
        repeat (10) @(negedge sys_clk);
        chk("wp standby", 8'h01, {7'h0, standby});
        wp = 1'b0;
        repeat (4) @(negedge sys_clk);
        rd_n(1'b1, 8'h00, 8'h00, 1);
        chk("rd wp", 8'h5a, rd[0]);
        $display("protect done");
    endtask

    // reset while the device holds sda low, then recovery and a read
    task automatic t_reset_mid();
        dev(straps, 1'b1, 1'b1);
        @(negedge sys_clk);
        reset = 1'b1;
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("rst oe", 8'h00, {7'h0, sda_oe});
        chk("rst standby", 8'h01, {7'h0, standby});
        bus_controller_inst.recover();
        bus_controller_inst.send({4'ha, straps, 1'b1}, ack);
        chk("rcv ack", 8'h01, {7'h0, ack});
        bus_controller_inst.recv(1'b0, rd[0]);
        bus_controller_inst.stop_c();
        chk("rst rd", 8'h5a, rd[0]);
        $display("reset done");
    endtask

    initial begin
        reset  = 1'b0;
        wp     = 1'b0;
        straps = 3'h5;
        #1 reset = 1'b1; // a real edge for the link side's async clear
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
        repeat (5) @(negedge sys_clk);
        chk("standby", 8'h01, {7'h0, standby});
        t_write_poll();
        t_mismatch();
        t_page_wrap();
        t_reads();
        t_protect();
        t_reset_mid();
        close_out();
    end
endmodule

`default_nettype wire
